// ---- logic/isck_cfg.svh ----
`ifndef ISCK_CFG_SVH
`define ISCK_CFG_SVH
`define ISCK_CLK_MHZ 125
`define ISCK_WORD_BITS 32
`define ISCK_FIFO_DEPTH 16
`define ISCK_POR_US 4000
`define ISCK_POR_CYC (`ISCK_POR_US * `ISCK_CLK_MHZ)
`define ISCK_CONV_US 133581
`define ISCK_CONV_CYC (`ISCK_CONV_US * `ISCK_CLK_MHZ)
`define ISCK_TEST_NS 12000
`define ISCK_TEST_CYC ((`ISCK_TEST_NS * `ISCK_CLK_MHZ + 999) / 1000)
`define ISCK_SCK_HALF_CYC 8
`define ISCK_CFG_RST 32'h00000000
`endif

// ---- logic/isck_pkg.sv ----
package isck_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_CONV = 3'h1,
    ST_SLEEP = 3'h2,
    ST_XLO = 3'h3,
    ST_XHI = 3'h4,
    ST_HOLD = 3'h5,
    ST_TEST = 3'h6,
    ST_EXT = 3'h7
  } dev_state_e;
endpackage

// ---- logic/isck_if.sv ----
`timescale 1ns/1ps
interface isck_if;
  logic sck_o;
  logic sck_oe;
  logic sck_pu;
  logic ext_sck_o;
  logic ext_sck_oe;
  logic sdo;
  logic sdo_oe;
  logic sdi;
  logic cs_n;
  logic sck_line;
  logic sdo_line;
  // a floating line without pull-up is taken to decay low
  assign sck_line = sck_oe ? sck_o : (ext_sck_oe ? ext_sck_o : sck_pu);
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  modport dev (input sck_line, input sdi, input cs_n, output sck_o, output sck_oe, output sck_pu,
               output sdo, output sdo_oe);
  modport host (input sck_line, input sdo_line, output sdi, output cs_n);
endinterface

// ---- logic/word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign in_ready = cnt_reg != FULL;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? ((wr_reg == LAST) ? '0 : wr_reg + AW'(1)) : wr_reg;
    rd_next = pop ? ((rd_reg == LAST) ? '0 : rd_reg + AW'(1)) : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // storage needs no reset; nothing reads a slot before it is written
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

// ---- logic/adc_port.sv ----
`timescale 1ns/1ps
`include "isck_cfg.svh"
// Summary of operation
// [R1] host keeps chip select low always
// [R2] clock mode sampled from SCK at POR end
// [R3] pull-up during POR; high SCK selects internal
// [R4] SCK and SDO high while converting
// [R5] conversion done: SCK, SDO low, sleep
// [R6] sleep half SCK period, then transfer
// [R7] SDI captured on every rising SCK edge
// [R8] SDO updated on each falling SCK edge
// [R9] 32nd rising edge ends transfer, converts
// [R10] pull-up off whenever SCK line low
// [R11] floating low SCK at CS fall: leave
// [R12] CS pulse while asleep pulls SCK low
// [R13] early CS rise re-enables SCK pull-up
// [R14] host keeps lines quiet during conversion
// [R15] received config applies to next conversion
// [R16] conversion, sleep, transfer repeat forever; the code stays in conversion while the result queue is empty
module adc_port #(
  parameter int POR_CYC = `ISCK_POR_CYC,
  parameter int CONV_CYC = `ISCK_CONV_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  isck_if.dev link,
  input wire logic [31:0] res_data,
  input wire logic res_valid,
  output logic res_ready,
  output logic [31:0] cfg_word,
  output logic cfg_strobe,
  output logic conv_busy,
  output logic int_mode
);
  localparam logic [23:0] POR_LAST = 24'(POR_CYC - 1);
  localparam logic [23:0] CONV_LAST = 24'(CONV_CYC - 1);
  localparam logic [23:0] HALF_LAST = 24'(`ISCK_SCK_HALF_CYC - 1);
  localparam logic [23:0] TEST_LAST = 24'(`ISCK_TEST_CYC - 1);
  localparam logic [5:0] LAST_BIT = 6'(`ISCK_WORD_BITS - 1);

  function automatic logic falls(input logic prev, input logic cur);
    falls = prev && !cur;
  endfunction

  logic [1:0] cs_sy, sck_sy, sdi_sy;
  logic cs_s, sck_s, sdi_s;
  isck_pkg::dev_state_e st_reg, st_next;
  logic [23:0] cnt_reg, cnt_next;
  logic [5:0] bit_reg, bit_next;
  isck_pkg::word_t out_sh_reg, out_sh_next, in_sh_reg, in_sh_next, cfg_reg, cfg_next;
  logic cfg_stb_reg, cfg_stb_next;
  logic pu_reg, pu_next, rearm_reg, rearm_next;
  logic sck_o_reg, sck_o_next, sdo_reg, sdo_next;
  logic cs_d_reg, mode_reg, mode_next;
  logic do_rise, pop;
  isck_pkg::word_t fifo_data;
  logic fifo_valid;

  assign cs_s = cs_sy[1];
  assign sck_s = sck_sy[1];
  assign sdi_s = sdi_sy[1];

  // results queue up while a transfer is busy; the source stalls on res_ready
  word_fifo #(.WIDTH(`ISCK_WORD_BITS), .DEPTH(`ISCK_FIFO_DEPTH)) result_q (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data(res_data),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cs_sy <= 2'h3;
      sck_sy <= 2'h3;
      sdi_sy <= 2'h0;
    end else begin
      cs_sy <= {cs_sy[0], link.cs_n};
      sck_sy <= {sck_sy[0], link.sck_line};
      sdi_sy <= {sdi_sy[0], link.sdi};
    end
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 24'h1;
    bit_next = bit_reg;
    out_sh_next = out_sh_reg;
    in_sh_next = in_sh_reg;
    cfg_next = cfg_reg;
    cfg_stb_next = 1'b0;
    mode_next = mode_reg;
    sck_o_next = sck_o_reg;
    sdo_next = sdo_reg;
    rearm_next = rearm_reg;
    pu_next = sck_s || rearm_reg; // R10
    do_rise = 1'b0;
    pop = 1'b0;
    case (st_reg)
      isck_pkg::ST_POR: begin
        pu_next = 1'b1; // R3
        sck_o_next = 1'b1;
        sdo_next = 1'b1;
        if (cnt_reg == POR_LAST) begin
          mode_next = sck_s; // R2 R3
          st_next = sck_s ? isck_pkg::ST_CONV : isck_pkg::ST_EXT;
          cnt_next = '0;
        end
      end
      isck_pkg::ST_CONV: begin
        sck_o_next = 1'b1; // R4
        sdo_next = 1'b1; // R4
        if (cnt_reg >= CONV_LAST) begin
          cnt_next = cnt_reg;
          if (fifo_valid) begin
            // the leading bit on the wire is the end-of-conversion flag
            pop = 1'b1;
            out_sh_next = {1'b0, fifo_data[30:0]};
            sck_o_next = 1'b0; // R5
            sdo_next = 1'b0; // R5
            st_next = isck_pkg::ST_SLEEP; // R5 R16
            cnt_next = '0;
          end
        end
      end
      isck_pkg::ST_SLEEP: begin
        if (cs_s) begin
          st_next = isck_pkg::ST_HOLD;
        end else if (cnt_reg == HALF_LAST) begin
          do_rise = 1'b1; // R6
        end
      end
      isck_pkg::ST_XLO: begin
        if (cnt_reg == HALF_LAST) begin
          do_rise = 1'b1;
        end
      end
      isck_pkg::ST_XHI: begin
        if (cnt_reg == HALF_LAST) begin
          sck_o_next = 1'b0;
          out_sh_next = {out_sh_reg[30:0], 1'b0};
          sdo_next = out_sh_reg[30]; // R8
          st_next = isck_pkg::ST_XLO;
          cnt_next = '0;
        end
      end
      isck_pkg::ST_HOLD: begin
        if (falls(cs_d_reg, cs_s)) begin
          sck_o_next = 1'b0; // R12
          rearm_next = 1'b0;
          st_next = isck_pkg::ST_TEST;
          cnt_next = '0;
        end
      end
      isck_pkg::ST_TEST: begin
        sck_o_next = 1'b0; // R12
        if (cs_s) begin
          rearm_next = 1'b1; // R13
          pu_next = 1'b1; // R13
          st_next = isck_pkg::ST_HOLD;
        end else if (cnt_reg == TEST_LAST) begin
          do_rise = 1'b1;
        end
      end
      default: begin
        sdo_next = 1'b1;
        cnt_next = cnt_reg;
      end
    endcase
    if (do_rise) begin
      sck_o_next = 1'b1;
      in_sh_next = {in_sh_reg[30:0], sdi_s}; // R7
      bit_next = bit_reg + 6'h1;
      cnt_next = '0;
      st_next = isck_pkg::ST_XHI;
      if (bit_reg == LAST_BIT) begin
        // config reaches the user only now, so it steers the conversion just starting
        cfg_next = {in_sh_reg[30:0], sdi_s}; // R15
        cfg_stb_next = 1'b1; // R15
        // sdo keeps the last bit across this rise so the host can still latch it; conv raises it next cycle
        bit_next = '0;
        st_next = isck_pkg::ST_CONV; // R9 R16
      end
    end
    if ((st_reg == isck_pkg::ST_XLO || st_reg == isck_pkg::ST_XHI) && cs_s) begin
      // abort: the partial input word is dropped, the old config stays
      st_next = isck_pkg::ST_CONV;
      bit_next = '0;
      cnt_next = '0;
    end
    if (st_reg != isck_pkg::ST_POR && st_reg != isck_pkg::ST_EXT && falls(cs_d_reg, cs_s) && !sck_s) begin
      st_next = isck_pkg::ST_EXT; // R11
      mode_next = 1'b0; // R11
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= isck_pkg::ST_POR;
      cnt_reg <= '0;
      bit_reg <= '0;
      out_sh_reg <= '0;
      in_sh_reg <= '0;
      cfg_reg <= `ISCK_CFG_RST;
      cfg_stb_reg <= 1'b0;
      mode_reg <= 1'b0;
      pu_reg <= 1'b1;
      rearm_reg <= 1'b0;
      sck_o_reg <= 1'b1;
      sdo_reg <= 1'b1;
      cs_d_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      out_sh_reg <= out_sh_next;
      in_sh_reg <= in_sh_next;
      cfg_reg <= cfg_next;
      cfg_stb_reg <= cfg_stb_next;
      mode_reg <= mode_next;
      pu_reg <= pu_next;
      rearm_reg <= rearm_next;
      sck_o_reg <= sck_o_next;
      sdo_reg <= sdo_next;
      cs_d_reg <= cs_s;
    end
  end

  // with chip select high the clock pin is released, so only the pull-up can hold it
  assign link.sck_oe = mode_reg && !cs_s && st_reg != isck_pkg::ST_POR;
  assign link.sck_o = sck_o_reg;
  assign link.sck_pu = pu_reg;
  assign link.sdo = sdo_reg;
  assign link.sdo_oe = !cs_s && st_reg != isck_pkg::ST_POR;
  assign cfg_word = cfg_reg;
  assign cfg_strobe = cfg_stb_reg;
  assign conv_busy = st_reg == isck_pkg::ST_CONV;
  assign int_mode = mode_reg;
endmodule

// ---- logic/host_listener.sv ----
`timescale 1ns/1ps
`include "isck_cfg.svh"
module host_listener (
  input wire logic core_clk,
  input wire logic nrst,
  isck_if.host link,
  input wire logic [31:0] next_cfg,
  output logic cfg_taken,
  output logic [31:0] rx_word,
  output logic rx_valid,
  output logic eoc
);
  localparam logic [5:0] LAST_BIT = 6'(`ISCK_WORD_BITS - 1);
  logic [1:0] sck_sy, sdo_sy;
  logic sck_s, sdo_s, sck_d_reg;
  logic busy_reg, busy_next, taken_reg, taken_next, rxv_reg, rxv_next, eoc_reg, eoc_next;
  logic [5:0] bit_reg, bit_next;
  isck_pkg::word_t tx_reg, tx_next, rx_sh_reg, rx_sh_next, rx_reg, rx_next;

  assign sck_s = sck_sy[1];
  assign sdo_s = sdo_sy[1];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sck_sy <= 2'h3;
      sdo_sy <= 2'h3;
    end else begin
      sck_sy <= {sck_sy[0], link.sck_line};
      sdo_sy <= {sdo_sy[0], link.sdo_line};
    end
  end

  always_comb begin
    busy_next = busy_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_sh_next = rx_sh_reg;
    rx_next = rx_reg;
    taken_next = 1'b0;
    rxv_next = 1'b0;
    eoc_next = busy_reg ? eoc_reg : sdo_s;
    if (!busy_reg) begin
      // sdi only moves once the converter sleeps, never during a conversion
      if (!sdo_s && !sck_s) begin
        busy_next = 1'b1; // R14
        tx_next = next_cfg; // R7
        taken_next = 1'b1;
      end
    end else if (sck_s && !sck_d_reg) begin
      rx_sh_next = {rx_sh_reg[30:0], sdo_s}; // R8
      bit_next = bit_reg + 6'h1;
      if (bit_reg == LAST_BIT) begin
        rx_next = {rx_sh_reg[30:0], sdo_s};
        rxv_next = 1'b1;
        bit_next = '0;
        busy_next = 1'b0;
      end
    end else if (!sck_s && sck_d_reg) begin
      tx_next = {tx_reg[30:0], 1'b0}; // R7
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sck_d_reg <= 1'b1;
      busy_reg <= 1'b0;
      bit_reg <= '0;
      tx_reg <= '0;
      rx_sh_reg <= '0;
      rx_reg <= '0;
      taken_reg <= 1'b0;
      rxv_reg <= 1'b0;
      eoc_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      busy_reg <= busy_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_sh_reg <= rx_sh_next;
      rx_reg <= rx_next;
      taken_reg <= taken_next;
      rxv_reg <= rxv_next;
      eoc_reg <= eoc_next;
    end
  end

  assign link.cs_n = 1'b0; // R1
  assign link.sdi = tx_reg[31];
  assign cfg_taken = taken_reg;
  assign rx_word = rx_reg;
  assign rx_valid = rxv_reg;
  assign eoc = eoc_reg;
endmodule

// ---- tb/isck_link_sva.sv ----
`timescale 1ns/1ps
module isck_link_sva #(
  parameter int POR_CYC = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sck_line,
  input wire logic sdo_line,
  input wire logic sdi,
  input wire logic cs_n,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic sck_pu
);
  int cyc;
  logic [5:0] rises;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // rise count wraps after the 32nd so the first rise of each frame reads 1
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc <= 0;
      rises <= 6'h00;
    end else begin
      if (cyc < POR_CYC + 16) cyc <= cyc + 1;
      if ($rose(sck_line)) rises <= (rises == 6'h20) ? 6'h01 : rises + 6'h01;
    end
  end
  property p_por_mode;
    cyc == POR_CYC - 2 |-> !sdo_oe ##[1:8] (sck_oe && sdo_oe);
  endproperty
  a_por_mode: assert property (p_por_mode) else $error("clock mode not taken after power-on");
  property p_por_pullup;
    !sdo_oe && !cs_n |-> sck_pu;
  endproperty
  a_por_pullup: assert property (p_por_pullup) else $error("pull-up off during power-on");
  property p_done_low;
    $fell(sck_line) && (rises == 6'h20 || rises == 6'h00) |-> !sdo_line;
  endproperty
  a_done_low: assert property (p_done_low) else $error("sdo not low at conversion end");
  property p_sleep_len;
    $fell(sck_line) && (rises == 6'h20 || rises == 6'h00) |-> !sck_line [*8] ##1 sck_line;
  endproperty
  a_sleep_len: assert property (p_sleep_len) else $error("sleep length wrong");
  property p_sdi_stable;
    $rose(sck_line) |-> $stable(sdi) ##1 $stable(sdi);
  endproperty
  a_sdi_stable: assert property (p_sdi_stable) else $error("sdi moved at rising sck");
  property p_sdo_on_edge;
    $changed(sdo_line) |-> $changed(sck_line) ||
      (sdo_line && rises == 6'h20 && $past(sck_line, 1) && !$past(sck_line, 2));
  endproperty
  a_sdo_on_edge: assert property (p_sdo_on_edge) else $error("sdo changed off an sck edge");
  property p_end_frame;
    $rose(sck_line) && rises == 6'h1F |-> $stable(sdo_line) ##1 (sck_line && sdo_line) [*8];
  endproperty
  a_end_frame: assert property (p_end_frame) else $error("lines not high after last rise");
  property p_pu_off;
    $fell(sck_line) |-> ##[1:4] !sck_pu;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up stays on with sck low");
endmodule

// ---- tb/internal_sck_continuous_serial_port_test.sv ----
`timescale 1ns/1ps
module internal_sck_continuous_serial_port_test;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] res_data = 32'h0;
  logic res_valid = 1'b0;
  logic [31:0] next_cfg = 32'h0;
  logic res_ready, int_mode, int_mode2, cfg_taken, rx_valid, eoc, cfg_strobe, conv_busy;
  int n_strobe = 0;
  int n_taken = 0;
  logic [31:0] cfg_word, rx_word;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  isck_if link ();
  isck_if link2 ();
  always #4 core_clk = ~core_clk;
  adc_port #(.POR_CYC(20), .CONV_CYC(200)) i_adc_port (.core_clk(core_clk), .nrst(nrst), .link(link),
    .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready), .cfg_word(cfg_word),
    .cfg_strobe(cfg_strobe), .conv_busy(conv_busy), .int_mode(int_mode));
  // second device has no listener: the bench plays a host that pulses chip select
  adc_port #(.POR_CYC(20), .CONV_CYC(200)) i_adc_port_b (.core_clk(core_clk), .nrst(nrst), .link(link2),
    .res_data(res_data), .res_valid(res_valid), .res_ready(), .cfg_word(), .cfg_strobe(), .conv_busy(),
    .int_mode(int_mode2));
  host_listener i_host_listener (.core_clk(core_clk), .nrst(nrst), .link(link), .next_cfg(next_cfg),
    .cfg_taken(cfg_taken), .rx_word(rx_word), .rx_valid(rx_valid), .eoc(eoc));
  isck_link_sva #(.POR_CYC(20)) i_isck_link_sva (.core_clk(core_clk), .nrst(nrst), .sck_line(link.sck_line),
    .sdo_line(link.sdo_line), .sdi(link.sdi), .cs_n(link.cs_n), .sck_oe(link.sck_oe), .sdo_oe(link.sdo_oe),
    .sck_pu(link.sck_pu));
  function automatic logic [31:0] wd(input int k);
    return 32'hA5C3_0F00 ^ 32'(k << 27) ^ 32'(k);
  endfunction
  function automatic logic [31:0] cfgv(input int k);
    return 32'h3C5A_0000 + 32'(k);
  endfunction
  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the 17th word is offered to a full buffer and must be dropped
  task automatic t_fill();
    chk(cfg_word, 32'h0);
    for (int k = 0; k < 17; k++) begin
      @(negedge core_clk);
      chk({31'h0, res_ready}, {31'h0, (k < 16)});
      res_data = wd(k);
      res_valid = 1'b1;
    end
    @(negedge core_clk);
    res_valid = 1'b0;
  endtask
  task automatic t_stream();
    int i;
    for (int k = 0; k < 16; k++) begin
      for (i = 0; i < 2000 && rx_valid !== 1'b1; i++) @(negedge core_clk);
      chk(rx_word, wd(k) & 32'h7FFF_FFFF);
      chk(cfg_word, cfgv(k));
      chk({31'h0, int_mode}, 32'h1);
      next_cfg = cfgv(k + 1);
      @(negedge core_clk);
    end
    chk(32'(n_strobe), 32'h10);
    chk(32'(n_taken), 32'h10);
  endtask
  task automatic t_idle();
    int n = 0;
    repeat (1000) begin
      @(negedge core_clk);
      if (rx_valid === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    chk({29'h0, link.sck_line, link.sdo_line, eoc}, 32'h7);
    chk({31'h0, conv_busy}, 32'h1);
    chk({31'h0, res_ready}, 32'h1);
  endtask
  task automatic t_status();
    chk({31'h0, int_mode2}, 32'h1);
    link2.cs_n = 1'b0;
    repeat (12) @(negedge core_clk);
    chk({31'h0, link2.sck_line}, 32'h0);
    link2.cs_n = 1'b1;
    repeat (12) @(negedge core_clk);
    chk({30'h0, link2.sck_pu, link2.sck_line}, 32'h3);
    link2.ext_sck_oe = 1'b1;
    link2.cs_n = 1'b0;
    repeat (12) @(negedge core_clk);
    chk({31'h0, int_mode2}, 32'h0);
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      conclude();
    end
  end
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge core_clk) begin
    if (cfg_strobe === 1'b1) n_strobe++;
    if (cfg_taken === 1'b1) n_taken++;
  end
  initial begin
    link.ext_sck_o = 1'b0;
    link.ext_sck_oe = 1'b0;
    link2.ext_sck_o = 1'b0;
    link2.ext_sck_oe = 1'b0;
    link2.cs_n = 1'b1;
    link2.sdi = 1'b0;
    next_cfg = cfgv(0);
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    t_fill();
    t_stream();
    t_idle();
    t_status();
    conclude();
  end
endmodule
